// File: sfp_pkg.sv
// shared constants and types of the serial flash pin interface
package sfp_pkg;

   // data-line widths of the shifter
   localparam logic [1:0] WID_SINGLE = 2'h0;
   localparam logic [1:0] WID_DUAL = 2'h1;
   localparam logic [1:0] WID_QUAD = 2'h2;

   // bits moved per serial clock edge in each width, and bits in one byte
   localparam logic [3:0] BITS_SINGLE = 4'h1;
   localparam logic [3:0] BITS_DUAL = 4'h2;
   localparam logic [3:0] BITS_QUAD = 4'h4;
   localparam logic [3:0] BITS_BYTE = 4'h8;

   // status word layout
   localparam int SR_W = 7;
   localparam int SR_BP_LSB = 0;
   localparam int SR_QE = 4;
   localparam int SR_SWD = 5;
   localparam int SR_PFS = 6;
   localparam logic [6:0] SR_PROT_MASK = 7'h3f;
   localparam logic [6:0] SR_RST = 7'h00;

   // synchroniser lanes
   localparam int PIN_W = 6;
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_D0 = 2;

   localparam int BYTE_W = 8;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_PAUSE = 2'b10,
      ST_RESET = 2'b11
   } sfp_state_t;

endpackage : sfp_pkg

// File: sfp_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module sfp_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfp_sync_t;

   sfp_sync_t r;
   sfp_sync_t r_nxt;

   // the first stage feeds only the second
   always_comb begin
      r_nxt.s1 = pin_i;
      r_nxt.s2 = r.s1;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign sync_o = r.s2;

endmodule : sfp_sync

// File: sfp_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
module sfp_buf2 #(
   parameter int W = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);

   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic [1:0] cnt;
      logic wp;
      logic rp;
   } sfp_buf_t;

   sfp_buf_t r;
   sfp_buf_t r_nxt;
   logic push;
   logic pop;

   assign in_ready_o = (r.cnt != 2'h2);
   assign out_valid_o = (r.cnt != 2'h0);
   assign out_data_o = r.mem[r.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // push and pop in one cycle keep the count
   always_comb begin
      r_nxt = r;
      if (push) begin
         r_nxt.mem[r.wp] = in_data_i;
         r_nxt.wp = ~r.wp;
      end
      if (pop) begin
         r_nxt.rp = ~r.rp;
      end
      case ({push, pop})
         2'b10: r_nxt.cnt = r.cnt + 2'h1;
         2'b01: r_nxt.cnt = r.cnt - 2'h1;
         default: r_nxt.cnt = r.cnt;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

endmodule : sfp_buf2

// File: sfp_core.sv
// pin-level front end of a serial flash: select, shift, protect, pause
// Function
// R1 - chip select high: deselected, outputs high impedance, standby
// R2 - chip select high: data inputs ignored, nothing captured
// R3 - chip select low: leave standby, accept instructions and data
// R4 - after power-up only a high-to-low select edge enables the device
// R5 - single mode: input line sampled on each rising serial clock edge
// R6 - single mode: output line updated on each falling serial clock edge
// R7 - dual/quad: lines bidirectional, sample on rise, drive from fall
// R8 - quad: protect pin is data line 2, pause/reset pin data line 3
// R9 - write-disable set and protect low: refuse protected status bits
// R10 - write-disable clear: status writes allowed whatever the pin
// R11 - quad enable set: protect function off, pin is data line 2 only
// R12 - quad enable set: pause and reset off, pin is data line 3 only
// R13 - quad enable clear: pin-function bit picks pause (0) or reset (1)
// R14 - pause while selected freezes shifting, keeps partial sequence
// R15 - pause and select both low: output line high impedance
// R16 - pause released: shifting continues where it stopped
// R17 - reset input low: held in reset, outputs high impedance
// R18 - master avoids hardware reset during internal write or erase
// R19 - both clock idle levels: latch on rise, change after fall
// R20 - quad: all four lines are bidirectional data lines 0 to 3
// R21 - select rising edge abandons any partial instruction
`timescale 1ns/100ps
module sfp_core (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic data_line_0_i,
   input wire logic data_line_1_i,
   input wire logic data_line_2_i,
   input wire logic data_line_3_i,
   output logic data_line_0_o,
   output logic data_line_1_o,
   output logic data_line_2_o,
   output logic data_line_3_o,
   output logic data_line_0_oe_o,
   output logic data_line_1_oe_o,
   output logic data_line_2_oe_o,
   output logic data_line_3_oe_o,
   input wire logic [1:0] width_i,
   input wire logic tx_en_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o,
   output logic rx_overrun_o,
   input wire logic sr_wr_i,
   input wire logic [6:0] sr_wr_data_i,
   output logic [6:0] sr_o,
   output logic sr_wr_refused_o,
   output logic standby_o,
   output logic paused_o,
   output logic in_reset_o
);

   typedef struct packed {
      sfp_pkg::sfp_state_t st;
      logic armed;
      logic sck_d;
      logic [7:0] rx_sh;
      logic [3:0] rx_cnt;
      logic [7:0] rx_byte;
      logic rx_push;
      logic overrun;
      logic [7:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [3:0] dout;
      logic [6:0] sr;
      logic refused;
   } sfp_core_t;

   localparam sfp_core_t CORE_RST = '{st: sfp_pkg::ST_STANDBY,
      sr: sfp_pkg::SR_RST, default: '0};

   sfp_core_t r;
   sfp_core_t r_nxt;
   logic [5:0] pin_s;
   logic cs_s;
   logic sck_s;
   logic [3:0] line_s;
   logic qe;
   logic pfs;
   logic swd;
   logic wp_n;
   logic hold_n;
   logic hwrst_n;
   logic [1:0] wid;
   logic [3:0] nbits;
   logic rise;
   logic fall;
   logic do_rx;
   logic do_tx;
   logic buf_ready;
   logic [3:0] oe;
   logic [7:0] tx_src;

   // every pin level crosses two flops before use
   sfp_sync #(
      .W(sfp_pkg::PIN_W)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i({data_line_3_i, data_line_2_i, data_line_1_i, data_line_0_i,
              sck_i, cs_n_i}),
      .sync_o(pin_s)
   );

   assign cs_s = pin_s[sfp_pkg::PIN_CS];
   assign sck_s = pin_s[sfp_pkg::PIN_SCK];
   assign line_s = pin_s[sfp_pkg::PIN_D0 +: 4];

   // status fields and shared-pin functions
   assign qe = r.sr[sfp_pkg::SR_QE];
   assign pfs = r.sr[sfp_pkg::SR_PFS];
   assign swd = r.sr[sfp_pkg::SR_SWD];
   assign wp_n = qe ? 1'b1 : line_s[2]; // [R11]
   assign hold_n = (qe || pfs) ? 1'b1 : line_s[3]; // [R12] [R13]
   assign hwrst_n = (qe || !pfs) ? 1'b1 : line_s[3]; // [R12] [R13]

   // quad width needs quad enable, else lines 2/3 keep pin duties
   always_comb begin
      wid = width_i;
      if (width_i == sfp_pkg::WID_QUAD && !qe) begin
         wid = sfp_pkg::WID_SINGLE; // [R8]
      end
      case (wid)
         sfp_pkg::WID_DUAL: nbits = sfp_pkg::BITS_DUAL;
         sfp_pkg::WID_QUAD: nbits = sfp_pkg::BITS_QUAD;
         default: nbits = sfp_pkg::BITS_SINGLE;
      endcase
   end

   // edges found by the system clock work for either idle level
   assign rise = sck_s && !r.sck_d; // [R19]
   assign fall = !sck_s && r.sck_d; // [R19]

   // multi-bit input only while the device is not driving
   assign do_rx = (r.st == sfp_pkg::ST_ACTIVE) && !cs_s && hold_n && // [R2]
      hwrst_n && rise && (wid == sfp_pkg::WID_SINGLE || !tx_en_i); // [R5] [R7]
   assign do_tx = (r.st == sfp_pkg::ST_ACTIVE) && !cs_s && hold_n &&
      hwrst_n && fall && tx_en_i &&
      (r.tx_cnt != 4'h0 || tx_valid_i); // [R6] [R7]
   assign tx_src = (r.tx_cnt == 4'h0) ? tx_data_i : r.tx_sh;

   // next-state logic of the whole front end
   always_comb begin
      r_nxt = r;
      r_nxt.sck_d = sck_s;
      r_nxt.rx_push = 1'b0;
      r_nxt.refused = 1'b0;
      if (cs_s) begin
         r_nxt.armed = 1'b1; // [R4]
      end
      case (r.st)
         sfp_pkg::ST_STANDBY: begin
            if (!cs_s && r.armed) begin
               r_nxt.st = sfp_pkg::ST_ACTIVE; // [R3] [R4]
            end
         end
         sfp_pkg::ST_ACTIVE: begin
            if (cs_s) begin
               r_nxt.st = sfp_pkg::ST_STANDBY;
               r_nxt.rx_cnt = 4'h0; // [R21]
               r_nxt.tx_cnt = 4'h0; // [R21]
            end else if (!hold_n) begin
               r_nxt.st = sfp_pkg::ST_PAUSE; // [R14]
            end
         end
         sfp_pkg::ST_PAUSE: begin
            // partial bytes stay put while frozen
            if (cs_s) begin
               r_nxt.st = sfp_pkg::ST_STANDBY;
               r_nxt.rx_cnt = 4'h0; // [R21]
               r_nxt.tx_cnt = 4'h0;
            end else if (hold_n) begin
               r_nxt.st = sfp_pkg::ST_ACTIVE; // [R16]
            end
         end
         sfp_pkg::ST_RESET: begin
            if (hwrst_n) begin
               r_nxt.st = sfp_pkg::ST_STANDBY; // [R17]
            end
         end
         default: r_nxt.st = sfp_pkg::ST_STANDBY;
      endcase
      // input shifter, msb first
      if (do_rx) begin
         case (wid)
            sfp_pkg::WID_DUAL: r_nxt.rx_sh = {r.rx_sh[5:0], line_s[1:0]};
            sfp_pkg::WID_QUAD: r_nxt.rx_sh = {r.rx_sh[3:0], line_s}; // [R20]
            default: r_nxt.rx_sh = {r.rx_sh[6:0], line_s[0]}; // [R5]
         endcase
         r_nxt.rx_cnt = r.rx_cnt + nbits;
         if (r_nxt.rx_cnt >= sfp_pkg::BITS_BYTE) begin
            r_nxt.rx_cnt = 4'h0;
            r_nxt.rx_byte = r_nxt.rx_sh;
            r_nxt.rx_push = 1'b1;
         end
      end
      // a byte arriving while the buffer is full is lost, not stalled
      if (r.rx_push && !buf_ready) begin
         r_nxt.overrun = 1'b1;
      end else if (r.st == sfp_pkg::ST_STANDBY && !cs_s) begin
         r_nxt.overrun = 1'b0;
      end
      // output shifter, launched from the falling edge
      if (do_tx) begin
         case (wid)
            sfp_pkg::WID_DUAL: r_nxt.dout = {2'h0, tx_src[7:6]}; // [R7]
            sfp_pkg::WID_QUAD: r_nxt.dout = tx_src[7:4]; // [R20]
            default: r_nxt.dout = {2'h0, tx_src[7], 1'h0}; // [R6]
         endcase
         r_nxt.tx_sh = tx_src << nbits;
         r_nxt.tx_cnt = ((r.tx_cnt == 4'h0) ? sfp_pkg::BITS_BYTE : r.tx_cnt)
            - nbits;
      end
      // status writes with protect gating
      if (sr_wr_i) begin
         if (swd && !wp_n) begin
            r_nxt.refused = 1'b1; // [R9]
            r_nxt.sr = (r.sr & sfp_pkg::SR_PROT_MASK) |
               (sr_wr_data_i & ~sfp_pkg::SR_PROT_MASK); // [R9]
         end else begin
            r_nxt.sr = sr_wr_data_i; // [R10]
         end
      end
      // hardware reset wins over state, bit counts and byte strobe; status word and armed are left alone
      if (!hwrst_n) begin
         r_nxt.st = sfp_pkg::ST_RESET; // [R17]
         r_nxt.rx_cnt = 4'h0;
         r_nxt.tx_cnt = 4'h0;
         r_nxt.rx_push = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= CORE_RST;
      end else begin
         r <= r_nxt;
      end
   end

   // received bytes wait here so a slow reader can fall two bytes behind; a third is lost
   sfp_buf2 #(
      .W(sfp_pkg::BYTE_W)
   ) u_buf (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(r.rx_push),
      .in_ready_o(buf_ready),
      .in_data_i(r.rx_byte),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o(rx_data_o)
   );

   // drivers enabled only while active, driving and not paused
   always_comb begin
      oe = 4'h0;
      if (r.st == sfp_pkg::ST_ACTIVE && tx_en_i && !cs_s && hold_n &&
          hwrst_n) begin
         case (wid)
            sfp_pkg::WID_DUAL: oe = 4'h3;
            sfp_pkg::WID_QUAD: oe = 4'hf; // [R8] [R20]
            default: oe = 4'h2;
         endcase
      end
   end // [R1] [R15] [R17]

   assign data_line_0_oe_o = oe[0];
   assign data_line_1_oe_o = oe[1];
   assign data_line_2_oe_o = oe[2];
   assign data_line_3_oe_o = oe[3];
   assign data_line_0_o = r.dout[0];
   assign data_line_1_o = r.dout[1];
   assign data_line_2_o = r.dout[2];
   assign data_line_3_o = r.dout[3];
   assign tx_ready_o = do_tx && (r.tx_cnt == 4'h0);
   assign rx_overrun_o = r.overrun;
   assign sr_o = r.sr;
   assign sr_wr_refused_o = r.refused;
   assign standby_o = (r.st == sfp_pkg::ST_STANDBY); // [R1]
   assign paused_o = (r.st == sfp_pkg::ST_PAUSE);
   assign in_reset_o = (r.st == sfp_pkg::ST_RESET);

   // checks next to the logic
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   standby_hiz_a: assert property ( // [R1]
      (r.st == sfp_pkg::ST_STANDBY) |-> (oe == 4'h0))
      else $error("outputs driven in standby");

   cs_high_ignore_a: assert property ( // [R2]
      cs_s && (r.st != sfp_pkg::ST_ACTIVE) |=> !r.rx_push)
      else $error("byte captured while deselected");

   select_wake_a: assert property ( // [R3]
      (r.st == sfp_pkg::ST_STANDBY) && !cs_s && r.armed && hwrst_n
      |=> (r.st == sfp_pkg::ST_ACTIVE))
      else $error("selection did not wake the device");

   powerup_edge_a: assert property ( // [R4]
      !r.armed |-> (r.st != sfp_pkg::ST_ACTIVE))
      else $error("active before a select edge");

   rise_sample_a: assert property ( // [R5]
      do_rx && (wid == sfp_pkg::WID_SINGLE)
      |=> (r.rx_sh[0] == $past(line_s[0])) && (r.rx_sh[7:1] ==
      $past(r.rx_sh[6:0])))
      else $error("input bit not sampled on rise");

   fall_update_a: assert property ( // [R6] [R7] [R19]
      (r.dout != $past(r.dout)) |-> $past(fall))
      else $error("output changed away from a falling edge");

   quad_lines_a: assert property ( // [R8] [R20]
      (oe[3:2] != 2'h0) |-> qe && (oe == 4'hf))
      else $error("lines 2 and 3 driven without quad enable");

   prot_refuse_a: assert property ( // [R9] [R11]
      sr_wr_i && swd && !qe && !line_s[2]
      |=> (r.sr[5:0] == $past(r.sr[5:0])) && r.refused)
      else $error("protected status bits changed");

   prot_free_a: assert property ( // [R10]
      sr_wr_i && !swd |=> (r.sr == $past(sr_wr_data_i)) && !r.refused)
      else $error("unprotected status write lost");

   qe_no_pin_a: assert property ( // [R12]
      qe && (r.st != sfp_pkg::ST_RESET) |=> (r.st != sfp_pkg::ST_PAUSE) ||
      $past(r.st == sfp_pkg::ST_PAUSE))
      else $error("pause entered with quad enable set");

   pause_freeze_a: assert property ( // [R14] [R15]
      (r.st == sfp_pkg::ST_PAUSE) && $past(r.st == sfp_pkg::ST_PAUSE)
      |-> $stable(r.rx_sh) && $stable(r.rx_cnt) && (oe == 4'h0))
      else $error("shifter moved while paused");

   pause_resume_a: assert property ( // [R16]
      (r.st == sfp_pkg::ST_PAUSE) && hold_n && !cs_s && hwrst_n
      |=> (r.st == sfp_pkg::ST_ACTIVE) && $stable(r.rx_cnt))
      else $error("no resume after pause release");

   hw_reset_a: assert property ( // [R13] [R17]
      !qe && pfs && !line_s[3] |=> (r.st == sfp_pkg::ST_RESET) &&
      (oe == 4'h0) ##1 (r.rx_cnt == 4'h0))
      else $error("reset input not obeyed");

   deselect_abandon_a: assert property ( // [R21]
      (r.st == sfp_pkg::ST_ACTIVE) && cs_s
      |=> (r.rx_cnt == 4'h0) && (r.tx_cnt == 4'h0))
      else $error("partial instruction kept over deselect");

   rx_byte_c: cover property (r.rx_push && buf_ready);
   pause_c: cover property ((r.st == sfp_pkg::ST_PAUSE) ##[1:40]
      (r.st == sfp_pkg::ST_ACTIVE));
   refused_c: cover property (r.refused);
   quad_tx_c: cover property (do_tx && (wid == sfp_pkg::WID_QUAD));

endmodule : sfp_core

// File: sfp_master.sv
// behavioural spi master driving the flash front end pins
`timescale 1ns/100ps
module sfp_master (
   input wire logic [3:0] dev_d_i,
   input wire logic [3:0] dev_oe_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic [3:0] line_o
);
   logic [3:0] m_d = 4'h0;
   logic [3:0] m_oe = 4'h0;
   logic [3:0] oe_seen = 4'h0;
   logic wp_n = 1'b1;
   logic pause_n = 1'b1;
   logic [3:0] idle;

   // released lines 0/1 show the inverse of the last bit so a stale value
   // cannot pass; lines 2/3 carry the protect and pause levels
   assign idle = {pause_n, wp_n, ~m_d[1:0]};

   // pin level: device first, then master, then idle level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         line_o[i] = dev_oe_i[i] ? dev_d_i[i] : m_oe[i] ? m_d[i] : idle[i];
      end
   end

   // select low from power-up, so the first edge must be made later
   initial begin
      cs_n_o = 1'b0;
      sck_o = 1'b0;
   end

   // clock idles at the mode level before selecting
   task automatic sel(input bit mode3);
      sck_o = mode3;
      #62.5 cs_n_o = 1'b0; // high-to-low edge before any byte
      #62.5;
   endtask : sel

   task automatic desel();
      #62.5 cs_n_o = 1'b1;
      m_oe = 4'h0;
      #62.5;
   endtask : desel

   // data set after the fall, device latches on the rise
   task automatic shift(input bit mode3, input int nb, input int n,
                        input logic [7:0] tx, input bit rd,
                        output logic [7:0] rx);
      logic [7:0] v;
      logic [7:0] s;
      v = tx;
      rx = 8'h00;
      for (int k = 0; k < n; k++) begin
         if (mode3) sck_o = 1'b0;
         if (nb == 1 || !rd) begin
            m_oe = (nb == 1) ? 4'h1 : (nb == 2) ? 4'h3 : 4'hf;
            m_d = 4'(v >> (8 - nb));
         end
         v = v << nb;
         #62.5 sck_o = 1'b1;
         s = (nb == 1) ? {7'h00, line_o[1]} : {4'h0, line_o};
         rx = (rx << nb) | (s & 8'((1 << nb) - 1));
         oe_seen = oe_seen | dev_oe_i;
         #62.5 if (!mode3) sck_o = 1'b0;
      end
   endtask : shift

   // stray clocks and data that a frozen device must not see
   task automatic junk(input int n);
      for (int k = 0; k < 2 * n; k++) begin
         sck_o = ~sck_o;
         m_d = ~m_d;
         #62.5;
      end
   endtask : junk
endmodule : sfp_master

// File: sfp_core_tb.sv
// self-checking bench of the serial flash pin front end
`timescale 1ns/100ps
module sfp_core_tb;
   logic sys_clk_i;
   logic reset_n_i;
   logic cs_n, sck;
   logic [3:0] line, dev_d, dev_oe;
   logic [1:0] width_i;
   logic tx_en_i, tx_valid_i;
   logic rx_ready_i, sr_wr_i;
   logic [7:0] tx_data_i;
   logic [6:0] sr_wr_data_i;
   logic [7:0] rx_data_o;
   logic [6:0] sr_o;
   logic tx_ready_o, rx_valid_o, rx_overrun_o, sr_wr_refused_o;
   logic standby_o, paused_o, in_reset_o;
   int err_count = 0;
   int n_tests = 0;
   int n_rdy;
   int rdy0;
   logic [7:0] got, a;
   // protect level, write word, expected word, expected refusal
   logic [15:0] rows [5] = '{16'h2040, 16'h0341, 16'hb162, 16'h3060,
                             16'h0000};
   logic [7:0] pat [3] = '{8'ha5, 8'h69, 8'hc3};

   // starts from unknown, so the first inversion lands on one
   always #4 sys_clk_i = (sys_clk_i !== 1'b1);

   // count byte-load strobes so each transfer can prove it took one byte
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         n_rdy <= 0;
      end else if (tx_ready_o === 1'b1) begin
         n_rdy <= n_rdy + 1;
      end
   end

   sfp_core sfp_core_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .cs_n_i(cs_n), .sck_i(sck), .data_line_0_i(line[0]),
      .data_line_1_i(line[1]), .data_line_2_i(line[2]),
      .data_line_3_i(line[3]), .data_line_0_o(dev_d[0]),
      .data_line_1_o(dev_d[1]), .data_line_2_o(dev_d[2]),
      .data_line_3_o(dev_d[3]), .data_line_0_oe_o(dev_oe[0]),
      .data_line_1_oe_o(dev_oe[1]), .data_line_2_oe_o(dev_oe[2]),
      .data_line_3_oe_o(dev_oe[3]), .width_i(width_i), .tx_en_i(tx_en_i),
      .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
      .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
      .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
      .rx_overrun_o(rx_overrun_o), .sr_wr_i(sr_wr_i),
      .sr_wr_data_i(sr_wr_data_i), .sr_o(sr_o),
      .sr_wr_refused_o(sr_wr_refused_o), .standby_o(standby_o),
      .paused_o(paused_o), .in_reset_o(in_reset_o));

   sfp_master sfp_master_i (.dev_d_i(dev_d), .dev_oe_i(dev_oe),
      .cs_n_o(cs_n), .sck_o(sck), .line_o(line));

   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] seen);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // every drive lands just after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick

   task automatic srw(input logic [6:0] d);
      sr_wr_data_i = d;
      sr_wr_i = 1'b1;
      tick(1);
      sr_wr_i = 1'b0;
   endtask : srw

   // bounded wait for a received byte, then one handshake
   task automatic pop(input logic [7:0] exp);
      int k;
      k = 0;
      tick(1);
      while (rx_valid_o !== 1'b1 && k < 200) begin
         tick(1);
         k++;
      end
      if (k == 200) begin
         err_count++;
         $display("ERROR rx_valid expected 1 seen %b", rx_valid_o);
         give_verdict();
      end else begin
         chk("rx_data", exp, rx_data_o);
         rx_ready_i = 1'b1;
         tick(1);
         rx_ready_i = 1'b0;
      end
   endtask : pop

   initial begin
      reset_n_i = 1'b0;
      width_i = 2'h0;
      tx_en_i = 1'b0;
      tx_valid_i = 1'b0;
      rx_ready_i = 1'b0;
      sr_wr_i = 1'b0;
      tx_data_i = 8'h00;
      sr_wr_data_i = 7'h00;
      tick(2);
      reset_n_i = 1'b1;
      tick(6);
      chk("standby", 8'h1, 8'(standby_o));
      chk("sr reset", 8'(sfp_pkg::SR_RST), 8'(sr_o));
      chk("oe reset", 8'h0, 8'(dev_oe));
      // select held low through reset is no edge, so nothing is taken
      sfp_master_i.shift(1'b0, 1, 8, 8'h5a, 1'b0, got);
      tick(8);
      chk("rx unarmed", 8'h0, 8'(rx_valid_o));
      sfp_master_i.desel();
      sfp_master_i.shift(1'b0, 1, 8, 8'h5a, 1'b0, got);
      tick(8);
      chk("rx deselected", 8'h0, 8'(rx_valid_o));
      chk("standby high", 8'h1, 8'(standby_o));
      sfp_master_i.sel(1'b0);
      tick(1);
      chk("selected", 8'h0, 8'(standby_o));
      sfp_master_i.desel();
      tick(1);
      // status writes against the protect pin, one row each
      foreach (rows[i]) begin
         sfp_master_i.wp_n = rows[i][15];
         tick(4);
         srw(rows[i][14:8]);
         chk("sr", 8'(rows[i][7:1]), 8'(sr_o));
         chk("refused", 8'(rows[i][0]), 8'(sr_wr_refused_o));
      end
      sfp_master_i.wp_n = 1'b1;
      srw(7'h10);
      // one byte per width, msb on the highest line
      for (int w = 0; w < 3; w++) begin
         width_i = 2'(w);
         sfp_master_i.sel(1'b0);
         sfp_master_i.shift(1'b0, 1 << w, 8 >> w, pat[w], 1'b0, got);
         sfp_master_i.desel();
         pop(pat[w]);
      end
      tx_en_i = 1'b1;
      tx_valid_i = 1'b1;
      // idle-high clock: device drives from falls, master latches rises
      for (int w = 0; w < 3; w++) begin
         width_i = 2'(w);
         tx_data_i = ~pat[w];
         sfp_master_i.oe_seen = 4'h0;
         rdy0 = n_rdy;
         sfp_master_i.sel(1'b1);
         sfp_master_i.shift(1'b1, 1 << w, 8 >> w, 8'h3c, w != 0, got);
         sfp_master_i.desel();
         chk("tx byte", ~pat[w], got);
         chk("oe lines", 8'(w == 0 ? 4'h2 : w == 1 ? 4'h3 : 4'hf),
             8'(sfp_master_i.oe_seen));
         chk("tx_ready", 8'h1, 8'(n_rdy - rdy0));
         if (w == 0) pop(8'h3c);
         else tick(1);
      end
      tx_en_i = 1'b0;
      tx_valid_i = 1'b0;
      width_i = 2'h0;
      srw(7'h00);
      // three bytes to a stalled consumer: two kept, the third lost
      sfp_master_i.sel(1'b0);
      foreach (pat[i]) sfp_master_i.shift(1'b0, 1, 8, pat[i], 1'b0, got);
      sfp_master_i.desel();
      tick(1);
      chk("overrun", 8'h1, 8'(rx_overrun_o));
      pop(pat[0]);
      pop(pat[1]);
      tick(2);
      chk("drained", 8'h0, 8'(rx_valid_o));
      sfp_master_i.sel(1'b0);
      tick(1);
      chk("overrun cleared", 8'h0, 8'(rx_overrun_o));
      sfp_master_i.shift(1'b0, 1, 5, 8'hff, 1'b0, got);
      sfp_master_i.desel();
      sfp_master_i.sel(1'b0);
      sfp_master_i.shift(1'b0, 1, 8, 8'h5a, 1'b0, got);
      sfp_master_i.desel();
      pop(8'h5a);
      tick(4);
      chk("one byte only", 8'h0, 8'(rx_valid_o));
      tx_en_i = 1'b1;
      tx_valid_i = 1'b1;
      tx_data_i = 8'h81;
      // pause in mid-byte with stray clocks, then finish the byte
      sfp_master_i.sel(1'b1);
      sfp_master_i.shift(1'b1, 1, 4, 8'hc3, 1'b0, a);
      sfp_master_i.pause_n = 1'b0;
      tick(4);
      chk("paused", 8'h1, 8'(paused_o));
      chk("out released", 8'h0, 8'(dev_oe[1]));
      sfp_master_i.junk(2);
      sfp_master_i.pause_n = 1'b1;
      tick(4);
      sfp_master_i.shift(1'b1, 1, 4, 8'h30, 1'b0, got);
      sfp_master_i.desel();
      chk("tx over pause", 8'h81, {a[3:0], got[3:0]});
      pop(8'hc3);
      srw(7'h40);
      // line 3 as reset, pulled while no internal write runs
      sfp_master_i.sel(1'b0);
      sfp_master_i.pause_n = 1'b0;
      tick(4);
      chk("in reset", 8'h1, 8'(in_reset_o));
      chk("oe in reset", 8'h0, 8'(dev_oe));
      chk("sr kept", 8'h40, 8'(sr_o));
      sfp_master_i.pause_n = 1'b1;
      tick(4);
      // armed survives the reset, so the held select wakes it at once
      chk("reset left", 8'h0, 8'({in_reset_o, standby_o}));
      sfp_master_i.desel();
      tick(1);
      tx_en_i = 1'b0;
      tx_valid_i = 1'b0;
      srw(7'h50);
      sfp_master_i.pause_n = 1'b0;
      tick(4);
      chk("quad line 3", 8'h0, 8'({in_reset_o, paused_o}));
      sfp_master_i.pause_n = 1'b1;
      give_verdict();
   end
endmodule : sfp_core_tb
